/* rtl/sbha_agent.sv */
// Behaviour
// RQ1: Address lines are inputs; drive them only for snoops on behalf of PCI.
// RQ2: Request strobe marks the first of two request cycles.
// RQ3: Address parity 1 covers bits 35:24, parity 0 covers 23:3.
// RQ4: Flag address error when address parity fails on a request.
// RQ5: Flag bus error on an unrecoverable protocol violation.
// RQ6: Bus initialize ends PCI work and clears queues; config and log kept.
// RQ7: Priority request gains address bus and wins over symmetric agents.
// RQ8: Hold symmetric request 0 in reset, release two clocks after.
// RQ9: Data bus owner holds data bus busy for multi-cycle transfers.
// RQ10: Data check bits carry ECC only, never parity.
// RQ11: Addressed agent asserts defer when global observation unsure.
// RQ12: Data ready only in cycles moving valid data.
// RQ13: Never assert snoop hit or hit-modified, never stall snoops.
// RQ14: Soft reset pulses on request, optional in hard reset, never power-good.
// RQ15: Locked sequence blocks PCI to DRAM; forward lock when PCI targeted.
// RQ16: Command lines give snoop type first clock, rest second clock.
// RQ17: Request parity is even over strobe and five command lines.
// RQ18: Response code idle 000, normal 111, retry, defer; parity protects.
// RQ19: Target asserts target ready when it can enter data phase.
// RQ20: Internal arbitration: grant input is a request, request out a grant.
// RQ21: External arbitration: request out asks, grant in means owned.
// RQ22: Third-party 00 normal, 10 retry, 11 defer, 01 reserved.
// RQ23: Priority request only after bridge arbitration ownership.
`timescale 1ns/1ps
`include "sbha_map.svh"
module sbha_agent
  import sbha_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic hard_rst,
  input wire logic pwrgood_rst,
  // AXI4-Lite slave
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // System bus request side
  input wire sbha_req_s req_in,
  output sbha_req_s req_out,
  output logic req_oe_n,
  output logic address_error,
  output logic bus_error,
  input wire logic bus_initialize,
  output logic priority_request,
  output logic symmetric_request_0,
  output logic snoop_hit,
  output logic snoop_hit_modified,
  output logic defer_out,
  output sbha_rsp_s response,
  output logic target_ready_sys,
  // Data phase, user side
  input wire logic [63:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  output logic [63:0] data_out,
  output logic [7:0] data_check_bits,
  output logic data_ready,
  output logic data_bus_busy,
  input wire logic target_can_transfer,
  input wire logic pci_target,
  input wire logic no_global_obs,
  // Bridge arbitration and third party
  input wire logic bridge_grant_in,
  output logic bridge_request_out,
  input wire logic [1:0] third_party_control,
  // PCI side hooks
  input wire logic pci_snoop_req,
  input wire logic [35:3] pci_snoop_addr,
  output logic snoop_done,
  output logic pci_abort,
  output logic queue_flush,
  output logic pci_dram_block,
  output logic pci_lock_fwd,
  output logic soft_reset
);
  logic [31:0] ctrl_reg;
  logic [2:0] err_reg;
  logic aw_reg, w_reg;
  logic [4:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [1:0] boot_cnt_reg;
  logic second_reg;
  logic locked_reg;
  sbha_arb_e arb_reg, arb_next;
  logic [5:0] srst_cnt_reg;
  logic snoop_reg, snoop_cyc2_reg;
  logic addr_par_bad, req_par_bad, proto_bad;
  logic arb_int, pri_owned;

  // Address and request parity checks on each request cycle
  always_comb begin
    addr_par_bad = (req_in.aparity[1] != ^req_in.addr[35:24]) ||
      (req_in.aparity[0] != ^req_in.addr[23:3]); // [RQ3]
    req_par_bad = req_in.rparity != ^{req_in.strobe, req_in.cmd}; // [RQ17]
  end
  assign proto_bad = req_in.strobe && second_reg;

  // Second request cycle tracker
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      second_reg <= 1'b0;
    end else begin
      second_reg <= req_in.strobe && !second_reg; // [RQ2] [RQ16]
    end
  end

  // Error outputs, one cycle after the request cycle
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      address_error <= 1'b0;
      bus_error <= 1'b0;
    end else begin
      address_error <= (req_in.strobe || second_reg) && addr_par_bad; // [RQ4]
      bus_error <= proto_bad; // [RQ5]
    end
  end

  // Error log, survives bus initialize; set wins over clear
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      err_reg <= 3'h0;
    end else begin
      if (aw_reg && w_reg && awaddr_reg == `SBHA_ERR_OFS) begin
        err_reg <= err_reg & ~wdata_reg[2:0];
      end
      if ((req_in.strobe || second_reg) && addr_par_bad)
        err_reg[`SBHA_ER_ADDR] <= 1'b1;
      if (proto_bad)
        err_reg[`SBHA_ER_BUS] <= 1'b1;
      if ((req_in.strobe || second_reg) && req_par_bad)
        err_reg[`SBHA_ER_REQ] <= 1'b1;
    end
  end

  // Boot processor select counter
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      boot_cnt_reg <= 2'h0;
    end else if (boot_cnt_reg != 2'(`SBHA_BOOT_HOLD_CLK)) begin
      boot_cnt_reg <= boot_cnt_reg + 2'h1;
    end
  end
  assign symmetric_request_0 = sys_rst ||
    (boot_cnt_reg != 2'(`SBHA_BOOT_HOLD_CLK)); // [RQ8]

  // Lock tracking
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      locked_reg <= 1'b0;
    end else if (!req_in.lock) begin
      locked_reg <= 1'b0;
    end else if (req_in.strobe) begin
      locked_reg <= 1'b1;
    end
  end
  assign pci_dram_block = locked_reg || (req_in.strobe && req_in.lock); // [RQ15]
  assign pci_lock_fwd = pci_dram_block && pci_target; // [RQ15]

  // Bridge arbitration state
  assign arb_int = ctrl_reg[`SBHA_CTRL_ARB_INT];
  always_comb begin
    arb_next = arb_reg;
    case (arb_reg)
      SBHA_ARB_IDLE: begin
        if (arb_int && bridge_grant_in && !pci_snoop_req)
          arb_next = SBHA_ARB_LEND; // [RQ20]
        else if (pci_snoop_req)
          arb_next = arb_int ? SBHA_ARB_OWN : SBHA_ARB_WAIT;
      end
      SBHA_ARB_WAIT: begin
        if (bridge_grant_in) arb_next = SBHA_ARB_OWN; // [RQ21]
      end
      SBHA_ARB_OWN: begin
        if (snoop_done) arb_next = SBHA_ARB_IDLE;
      end
      SBHA_ARB_LEND: begin
        if (!bridge_grant_in) arb_next = SBHA_ARB_IDLE;
      end
      default: arb_next = SBHA_ARB_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      arb_reg <= SBHA_ARB_IDLE;
    end else if (bus_initialize) begin
      arb_reg <= SBHA_ARB_IDLE;
    end else begin
      arb_reg <= arb_next;
    end
  end
  assign pri_owned = arb_reg == SBHA_ARB_OWN;
  assign bridge_request_out = arb_int ? (arb_reg == SBHA_ARB_LEND) :
    (arb_reg == SBHA_ARB_WAIT || pri_owned); // [RQ20] [RQ21]
  assign priority_request = pri_owned && !snoop_cyc2_reg; // [RQ7] [RQ23]

  // Snoop request phase driven for PCI initiators
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      snoop_reg <= 1'b0;
      snoop_cyc2_reg <= 1'b0;
      req_out <= '0;
    end else if (bus_initialize) begin
      snoop_reg <= 1'b0;
      snoop_cyc2_reg <= 1'b0;
      req_out <= '0;
    end else begin
      snoop_reg <= pri_owned && !snoop_reg && !snoop_cyc2_reg &&
        ctrl_reg[`SBHA_CTRL_SNOOP];
      snoop_cyc2_reg <= snoop_reg;
      req_out.strobe <= pri_owned && !snoop_reg && !snoop_cyc2_reg; // [RQ2]
      req_out.addr <= pci_snoop_addr; // [RQ1]
      req_out.cmd <= 5'h00; // [RQ16]
      req_out.aparity <= {^pci_snoop_addr[35:24], ^pci_snoop_addr[23:3]};
      req_out.rparity <= ^{pri_owned && !snoop_reg && !snoop_cyc2_reg,
        5'h00}; // [RQ17]
      req_out.lock <= 1'b0;
    end
  end
  assign req_oe_n = !(snoop_reg || snoop_cyc2_reg); // [RQ1]
  assign snoop_done = snoop_cyc2_reg || (pri_owned &&
    !ctrl_reg[`SBHA_CTRL_SNOOP]);
  assign snoop_hit = 1'b0; // [RQ13]
  assign snoop_hit_modified = 1'b0; // [RQ13]

  // Response and data phase
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      response <= '0;
      defer_out <= 1'b0;
      target_ready_sys <= 1'b0;
    end else begin
      response.valid <= second_reg;
      defer_out <= second_reg && no_global_obs; // [RQ11]
      target_ready_sys <= second_reg && target_can_transfer; // [RQ19]
      if (!second_reg) begin
        response.code <= `SBHA_RSP_IDLE; // [RQ18]
        response.parity <= 1'b0;
      end else begin
        case (sbha_tp_e'(third_party_control)) // [RQ22]
          SBHA_TP_RETRY: response.code <= `SBHA_RSP_RETRY;
          SBHA_TP_DEFER: response.code <= `SBHA_RSP_DEFER;
          default: response.code <= `SBHA_RSP_NORMAL;
        endcase
        case (sbha_tp_e'(third_party_control)) // [RQ18]
          SBHA_TP_RETRY: response.parity <= ^`SBHA_RSP_RETRY;
          SBHA_TP_DEFER: response.parity <= ^`SBHA_RSP_DEFER;
          default: response.parity <= ^`SBHA_RSP_NORMAL;
        endcase
      end
    end
  end

  // Simple ECC: each check bit covers one byte lane interleave
  function automatic logic [7:0] ecc8(input logic [63:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 64; i++) begin
      c[i % 8] = c[i % 8] ^ d[i] ^ ((i / 8) % 2 == 1 ? d[(i + 9) % 64] : 1'b0);
    end
    return c;
  endfunction

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_out <= 64'h0;
      data_check_bits <= 8'h00;
      data_ready <= 1'b0;
      data_bus_busy <= 1'b0;
    end else if (bus_initialize) begin
      data_ready <= 1'b0;
      data_bus_busy <= 1'b0;
    end else begin
      data_ready <= tx_valid; // [RQ12]
      data_bus_busy <= tx_valid && !tx_last; // [RQ9]
      if (tx_valid) begin
        data_out <= tx_data;
        data_check_bits <= ecc8(tx_data); // [RQ10]
      end
    end
  end

  // PCI abort and queue flush on bus initialize
  assign pci_abort = bus_initialize; // [RQ6]
  assign queue_flush = bus_initialize; // [RQ6]

  // Soft reset pulse, never during power-good reset
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      srst_cnt_reg <= 6'h00;
    end else if (pwrgood_rst) begin
      srst_cnt_reg <= 6'h00;
    end else if (hard_rst && ctrl_reg[`SBHA_CTRL_BIST]) begin
      srst_cnt_reg <= 6'(`SBHA_SOFT_RST_CYC);
    end else if (aw_reg && w_reg && awaddr_reg == `SBHA_CTRL_OFS &&
                 wdata_reg[`SBHA_CTRL_SOFT_RST]) begin
      srst_cnt_reg <= 6'(`SBHA_SOFT_RST_CYC);
    end else if (srst_cnt_reg != 6'h00) begin
      srst_cnt_reg <= srst_cnt_reg - 6'h01;
    end
  end
  assign soft_reset = (srst_cnt_reg != 6'h00) && !pwrgood_rst; // [RQ14]

  // AXI write: capture address and data in either order
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      awaddr_reg <= 5'h00;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (aw_reg && w_reg) begin
        aw_reg <= 1'b0;
        w_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_reg && !s_axi_bvalid;
  assign s_axi_bresp = 2'b00;

  // Control register, kept across bus initialize
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_reg <= `SBHA_CTRL_RESET;
    end else if (aw_reg && w_reg && awaddr_reg == `SBHA_CTRL_OFS) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_reg[b]) ctrl_reg[b*8 +: 8] <= wdata_reg[b*8 +: 8];
      end
      ctrl_reg[`SBHA_CTRL_SOFT_RST] <= 1'b0;
    end
  end

  // AXI read
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case (s_axi_araddr)
        `SBHA_CTRL_OFS: s_axi_rdata <= ctrl_reg;
        `SBHA_STAT_OFS: s_axi_rdata <= {29'h0, pci_dram_block, pri_owned,
          locked_reg};
        `SBHA_ERR_OFS: s_axi_rdata <= {29'h0, err_reg};
        `SBHA_SNP_OFS: s_axi_rdata <= {30'h0, arb_reg};
        `SBHA_ID_OFS: s_axi_rdata <= `SBHA_ID_VALUE; // arbitrary value
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  // Checks
  boot_release_a: assert property ( // [RQ8]
    @(posedge ref_clk) disable iff (sys_rst)
    $fell(sys_rst) |-> ##2 !symmetric_request_0)
    else $error("boot request not released");
  no_hit_a: assert property ( // [RQ13]
    @(posedge ref_clk) disable iff (sys_rst)
    !snoop_hit && !snoop_hit_modified)
    else $error("snoop hit asserted");
  pri_after_own_a: assert property ( // [RQ23]
    @(posedge ref_clk) disable iff (sys_rst)
    priority_request && !arb_int |-> $past(bridge_grant_in))
    else $error("priority request without grant");
  addr_err_a: assert property ( // [RQ4]
    @(posedge ref_clk) disable iff (sys_rst)
    (req_in.strobe && addr_par_bad) |=> address_error)
    else $error("address error missing");
  data_ready_a: assert property ( // [RQ12]
    @(posedge ref_clk) disable iff (sys_rst)
    tx_valid && !bus_initialize |=> data_ready && data_out == $past(tx_data))
    else $error("data ready mismatch");
  tp_retry_a: assert property ( // [RQ22]
    @(posedge ref_clk) disable iff (sys_rst)
    second_reg && third_party_control == 2'b10 |=>
    response.code == `SBHA_RSP_RETRY)
    else $error("retry not forced");
  idle_rsp_a: assert property ( // [RQ18]
    @(posedge ref_clk) disable iff (sys_rst)
    !second_reg |=> response.code == `SBHA_RSP_IDLE)
    else $error("idle code wrong");
  srst_pg_a: assert property ( // [RQ14]
    @(posedge ref_clk) disable iff (sys_rst)
    pwrgood_rst |-> !soft_reset ##1 srst_cnt_reg == 6'h00)
    else $error("soft reset in power-good reset");
endmodule : sbha_agent

/* rtl/sbha_map.svh */
`ifndef SBHA_MAP_SVH
`define SBHA_MAP_SVH
// AXI4-Lite register byte offsets
`define SBHA_CTRL_OFS 5'h00
`define SBHA_STAT_OFS 5'h04
`define SBHA_ERR_OFS 5'h08
`define SBHA_SNP_OFS 5'h0C
`define SBHA_ID_OFS 5'h10
// Control register bit positions
`define SBHA_CTRL_ARB_INT 0
`define SBHA_CTRL_SOFT_RST 1
`define SBHA_CTRL_BIST 2
`define SBHA_CTRL_SNOOP 3
`define SBHA_CTRL_RESET 32'h0000_0000
// Status bit positions
`define SBHA_ST_LOCKED 0
`define SBHA_ST_PRI_OWN 1
`define SBHA_ST_PCI_BLOCK 2
// Error log bit positions
`define SBHA_ER_ADDR 0
`define SBHA_ER_BUS 1
`define SBHA_ER_REQ 2
// Timing
`define SBHA_BOOT_HOLD_CLK 2
`define SBHA_SOFT_RST_NS 1000
`define SBHA_CLK_NS 25
`define SBHA_SOFT_RST_CYC (`SBHA_SOFT_RST_NS / `SBHA_CLK_NS)
// Identification word; the value is arbitrary
`define SBHA_ID_VALUE 32'h5A5A_0001
// Response codes
`define SBHA_RSP_IDLE 3'h0
`define SBHA_RSP_RETRY 3'h1
`define SBHA_RSP_DEFER 3'h2
`define SBHA_RSP_RSVD 3'h3
`define SBHA_RSP_NORMAL 3'h7
`endif

/* rtl/sbha_pkg.sv */
package sbha_pkg;
  typedef enum logic [1:0] {
    SBHA_TP_ACCEPT = 2'b00,
    SBHA_TP_RSVD = 2'b01,
    SBHA_TP_RETRY = 2'b10,
    SBHA_TP_DEFER = 2'b11
  } sbha_tp_e;
  typedef enum logic [1:0] {
    SBHA_ARB_IDLE = 2'b00,
    SBHA_ARB_WAIT = 2'b01,
    SBHA_ARB_OWN = 2'b10,
    SBHA_ARB_LEND = 2'b11
  } sbha_arb_e;
  typedef struct packed {
    logic strobe;
    logic [4:0] cmd;
    logic [35:3] addr;
    logic [1:0] aparity;
    logic rparity;
    logic lock;
  } sbha_req_s;
  typedef struct packed {
    logic valid;
    logic [2:0] code;
    logic parity;
  } sbha_rsp_s;
endpackage : sbha_pkg

/* bench/sbha_bus_partner.sv */
`timescale 1ns/1ps
module sbha_bus_partner
  import sbha_pkg::*;
(
  input wire logic ref_clk,
  input wire logic bridge_request_out,
  output sbha_req_s req_drv,
  output logic bridge_grant_in,
  output logic [1:0] third_party_control
);
  bit ext_arb = 1;
  bit lend = 0;
  int grant_delay = 3;
  int wait_cnt = 0;
  // Idle bus at time zero
  initial begin
    req_drv = '0;
    bridge_grant_in = 1'h0;
    third_party_control = 2'h0;
  end
  // Slow external arbiter, or a second bridge asking to borrow
  always @(posedge ref_clk) begin
    wait_cnt <= bridge_request_out ? wait_cnt + 1 : 0;
    if (ext_arb) begin
      bridge_grant_in <= bridge_request_out && wait_cnt >= grant_delay;
    end else begin
      bridge_grant_in <= lend;
    end
  end
  // One request cycle with good parity
  function automatic sbha_req_s mk(input logic s, input logic [4:0] c,
    input logic [35:3] a, input logic lk);
    sbha_req_s r;
    r.strobe = s;
    r.cmd = c;
    r.addr = a;
    r.aparity = {^a[35:24], ^a[23:3]};
    r.rparity = ^{s, c};
    r.lock = lk;
    return r;
  endfunction : mk
  // Two-cycle request; bad flips address parity, request parity, strobe
  task automatic request(input logic [35:3] a, input logic lk,
    input logic [1:0] tp, input logic [2:0] bad);
    sbha_req_s r;
    third_party_control <= tp;
    r = mk(1'h1, 5'h06, a, lk);
    r.aparity[0] ^= bad[0];
    r.rparity ^= bad[1];
    req_drv <= r;
    @(posedge ref_clk);
    r = mk(bad[2], 5'h11, a, lk);
    r.aparity[0] ^= bad[0];
    r.rparity ^= bad[1];
    req_drv <= r;
    @(posedge ref_clk);
    req_drv <= '{1'h0, ~r.cmd, ~a, ~r.aparity, ~r.rparity, lk};
  endtask : request
  // Lock is held past the request until negated here
  task drop_lock;
    req_drv.lock <= 1'h0;
  endtask : drop_lock
endmodule : sbha_bus_partner

/* bench/test_system_bus_host_agent.sv */
`timescale 1ns/1ps
`include "sbha_map.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  num_errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module test_system_bus_host_agent
  import sbha_pkg::*;
;
  logic ref_clk = 1'h0, sys_rst = 1'h1, hard_rst = 1'h0, pwrgood_rst = 1'h0;
  logic [4:0] s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsv, third_party_control;
  sbha_req_s req_in, req_out, req_drv;
  sbha_rsp_s response;
  logic req_oe_n, address_error, bus_error, priority_request, defer_out;
  logic symmetric_request_0, snoop_hit, snoop_hit_modified, snoop_done;
  logic target_ready_sys, data_ready, data_bus_busy, bridge_grant_in;
  logic bridge_request_out, pci_abort, queue_flush, soft_reset;
  logic pci_dram_block, pci_lock_fwd;
  logic [63:0] tx_data = 64'h0, data_out;
  logic [7:0] data_check_bits;
  logic tx_valid = 1'h0, tx_last = 1'h0, bus_initialize = 1'h0;
  logic target_can_transfer = 1'h1, pci_target = 1'h0, no_global_obs = 1'h0;
  logic pci_snoop_req = 1'h0;
  logic [35:3] pci_snoop_addr = 33'h0;
  int num_errors = 0, n_compared = 0, n_address_error = 0, n_bus_error = 0;
  int n_bad_pri = 0, n_soft = 0, k;
  bit saw_bridge_req = 0, saw_pri = 0, saw_drive = 0;
  logic snp_rp;
  logic [1:0] snp_ap;
  sbha_tp_e tps[3] = '{SBHA_TP_ACCEPT, SBHA_TP_RETRY, SBHA_TP_DEFER};
  logic [2:0] exp_rsp[3] = '{`SBHA_RSP_NORMAL, `SBHA_RSP_RETRY,
    `SBHA_RSP_DEFER};
  // Shared request lines: agent drives only while its enable is low
  assign req_in = req_oe_n ? req_drv : req_out;
  // Parity of the request the agent drives; both come out zero when good
  assign snp_rp = ^{req_out.strobe, req_out.cmd, req_out.rparity};
  assign snp_ap = req_out.aparity ^
    {^req_out.addr[35:24], ^req_out.addr[23:3]};
  sbha_agent uut (.ref_clk, .sys_rst, .hard_rst, .pwrgood_rst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .req_in, .req_out, .req_oe_n, .address_error,
    .bus_error, .bus_initialize, .priority_request, .symmetric_request_0,
    .snoop_hit, .snoop_hit_modified, .defer_out, .response,
    .target_ready_sys, .tx_data, .tx_valid, .tx_last, .data_out,
    .data_check_bits, .data_ready, .data_bus_busy, .target_can_transfer,
    .pci_target, .no_global_obs, .bridge_grant_in, .bridge_request_out,
    .third_party_control, .pci_snoop_req, .pci_snoop_addr, .snoop_done,
    .pci_abort, .queue_flush, .pci_dram_block, .pci_lock_fwd, .soft_reset);
  sbha_bus_partner partner (.ref_clk, .bridge_request_out, .req_drv,
    .bridge_grant_in, .third_party_control);
  // Clock and watchdog
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    conclude();
  end
  // Bus monitor: error pulses, arbitration order, snoop address
  always @(posedge ref_clk) begin
    if (!sys_rst) begin
      if (address_error === 1'h1) n_address_error++;
      if (bus_error === 1'h1) n_bus_error++;
      if (soft_reset === 1'h1) n_soft++;
      if (bridge_request_out === 1'h1) saw_bridge_req = 1;
      if (priority_request === 1'h1) begin
        saw_pri = 1;
        if (partner.ext_arb && bridge_grant_in !== 1'h1) n_bad_pri++;
      end
      if (req_oe_n === 1'h0) begin
        saw_drive = 1;
        `CHK("snoop addr", pci_snoop_addr, req_out.addr)
        `CHK("snoop rp", 1'h0, snp_rp)
        `CHK("snoop ap", 2'h0, snp_ap)
      end
    end
  end
  task conclude;
    if (num_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  // Write: address and data offered together, each released when taken
  task axi_wr(input logic [4:0] a, input logic [31:0] d);
    int i;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    i = 0;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      i++;
    end while (s_axi_bvalid !== 1'h1 && i < 50);
    `CHK("bresp", 2'h0, s_axi_bresp)
    s_axi_bready <= 1'h0;
    if (s_axi_bvalid !== 1'h1) begin
      num_errors++;
      conclude();
    end
    @(posedge ref_clk);
  endtask : axi_wr
  task axi_rd(input logic [4:0] a);
    int i;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    i = 0;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      i++;
    end while (s_axi_rvalid !== 1'h1 && i < 50);
    rdv = s_axi_rdata;
    rsv = s_axi_rresp;
    s_axi_rready <= 1'h0;
    if (s_axi_rvalid !== 1'h1) begin
      num_errors++;
      conclude();
    end
    @(posedge ref_clk);
  endtask : axi_rd
  // Main sequence
  initial begin
    tick(6);
    sys_rst <= 1'h0;
    `CHK("sreq0 in reset", 1'h1, symmetric_request_0)
    tick(1);
    `CHK("sreq0 hold", 1'h1, symmetric_request_0)
    tick(2);
    `CHK("sreq0 free", 1'h0, symmetric_request_0)
    `CHK("addr idle", 1'h1, req_oe_n)
    axi_rd(`SBHA_CTRL_OFS);
    `CHK("ctrl reset", `SBHA_CTRL_RESET, rdv)
    axi_rd(`SBHA_ID_OFS);
    `CHK("id", `SBHA_ID_VALUE, rdv)
    axi_rd(5'h14);
    `CHK("unmapped resp", 2'h2, rsv)
    axi_wr(`SBHA_CTRL_OFS, 32'h8);
    for (k = 0; k < 3; k++) begin
      partner.request(33'h1_2345_6780 + k, 1'h0, tps[k], 3'h0);
      tick(1);
      `CHK("rsp code", exp_rsp[k], response.code)
      `CHK("rsp par", ^exp_rsp[k], response.parity)
      `CHK("target ready", 1'h1, target_ready_sys)
      tick(1);
      `CHK("rsp idle", `SBHA_RSP_IDLE, response.code)
    end
    `CHK("no addr err", 0, n_address_error)
    no_global_obs <= 1'h1;
    partner.request(33'h0_0000_1000, 1'h0, 2'h0, 3'h0);
    tick(1);
    `CHK("defer", 1'h1, defer_out)
    no_global_obs <= 1'h0;
    axi_wr(`SBHA_ERR_OFS, 32'hFFFF_FFFF);
    partner.request(33'h0_0000_2000, 1'h0, 2'h0, 3'h1);
    tick(2);
    `CHK("addr err", 1'h1, n_address_error > 0)
    partner.request(33'h0_0000_3000, 1'h0, 2'h0, 3'h2);
    tick(2);
    axi_rd(`SBHA_ERR_OFS);
    `CHK("log req", 1'h1, rdv[`SBHA_ER_REQ])
    `CHK("log addr", 1'h1, rdv[`SBHA_ER_ADDR])
    `CHK("no bus err", 0, n_bus_error)
    partner.request(33'h0_0000_4000, 1'h0, 2'h0, 3'h4);
    tick(2);
    `CHK("bus err", 1'h1, n_bus_error > 0)
    axi_wr(`SBHA_ERR_OFS, 32'hFFFF_FFFF);
    axi_rd(`SBHA_ERR_OFS);
    `CHK("log clear", 3'h0, rdv[2:0])
    pci_target <= 1'h1;
    partner.request(33'h0_0000_5000, 1'h1, 2'h0, 3'h0);
    tick(1);
    `CHK("lock block", 1'h1, pci_dram_block)
    `CHK("lock fwd", 1'h1, pci_lock_fwd)
    axi_rd(`SBHA_STAT_OFS);
    `CHK("stat lock", 1'h1, rdv[`SBHA_ST_LOCKED])
    partner.drop_lock();
    tick(3);
    `CHK("lock free", 1'h0, pci_dram_block)
    pci_target <= 1'h0;
    tx_data <= 64'h0123_4567_89AB_CDEF;
    tx_valid <= 1'h1;
    tick(1);
    tx_data <= 64'hFEDC_BA98_7654_3210;
    tx_last <= 1'h1;
    tick(1);
    `CHK("ready 1", 1'h1, data_ready)
    `CHK("data 1", 64'h0123_4567_89AB_CDEF, data_out)
    `CHK("busy", 1'h1, data_bus_busy)
    tx_valid <= 1'h0;
    tx_last <= 1'h0;
    tick(1);
    `CHK("data 2", 64'hFEDC_BA98_7654_3210, data_out)
    tick(1);
    `CHK("ready idle", 1'h0, data_ready)
    `CHK("busy idle", 1'h0, data_bus_busy)
    bus_initialize <= 1'h1;
    tick(1);
    `CHK("flush", 1'h1, queue_flush)
    `CHK("abort", 1'h1, pci_abort)
    bus_initialize <= 1'h0;
    axi_rd(`SBHA_CTRL_OFS);
    `CHK("ctrl kept", 32'h8, rdv)
    pci_snoop_addr <= 33'h0_ABCD_EF01;
    pci_snoop_req <= 1'h1;
    for (k = 0; k < 40 && snoop_done !== 1'h1; k++) tick(1);
    if (k == 40) begin
      num_errors++;
      conclude();
    end
    pci_snoop_req <= 1'h0;
    tick(2);
    `CHK("bridge req", 1, saw_bridge_req)
    `CHK("pri seen", 1, saw_pri)
    `CHK("pri order", 0, n_bad_pri)
    `CHK("snoop drive", 1, saw_drive)
    axi_wr(`SBHA_CTRL_OFS, 32'h1);
    partner.ext_arb <= 0;
    partner.lend <= 1;
    tick(4);
    `CHK("lend grant", 1'h1, bridge_request_out)
    axi_rd(`SBHA_SNP_OFS);
    `CHK("arb lend", SBHA_ARB_LEND, rdv[1:0])
    partner.lend <= 0;
    tick(4);
    `CHK("lend over", 1'h0, bridge_request_out)
    n_soft = 0;
    axi_wr(`SBHA_CTRL_OFS, 32'h2);
    tick(60);
    `CHK("soft pulse", `SBHA_SOFT_RST_CYC, n_soft)
    axi_wr(`SBHA_CTRL_OFS, 32'h4);
    hard_rst <= 1'h1;
    pwrgood_rst <= 1'h1;
    tick(3);
    `CHK("pwrgood quiet", 1'h0, soft_reset)
    pwrgood_rst <= 1'h0;
    tick(3);
    `CHK("bist", 1'h1, soft_reset)
    hard_rst <= 1'h0;
    `CHK("hit", 1'h0, snoop_hit)
    `CHK("hit mod", 1'h0, snoop_hit_modified)
    conclude();
  end
endmodule : test_system_bus_host_agent
